//--- common/tpio_regs.svh
`ifndef TPIO_REGS_SVH
`define TPIO_REGS_SVH

// Register indices; the byte address of a register is four times its index.
`define TPIO_IDX_A_DATA 3'h0
`define TPIO_IDX_B_DATA 3'h1
`define TPIO_IDX_C_DATA 3'h3
`define TPIO_IDX_A_DIR 3'h4
`define TPIO_IDX_B_DIR 3'h5
`define TPIO_IDX_C_DIR 3'h6
`define TPIO_IDX_IRQ_CTRL 3'h7
`define TPIO_IDX_HOLE 3'h2

// Address fields of haddr.
`define TPIO_IDX_LSB 2
`define TPIO_IDX_MSB 4
`define TPIO_ADDR_MSB 31
`define TPIO_ADDR_HI_LSB 5

// Reset values.
`define TPIO_DIR_RESET 8'h00
`define TPIO_CTRL_RESET 2'h1
`define TPIO_SYNC_RESET 25'h1ffffff

// Interrupt control field positions.
`define TPIO_CTRL_MASK_BIT 0
`define TPIO_CTRL_LEVEL_BIT 1

// Bus response and transfer-type bit.
`define TPIO_HRESP_OKAY 1'b0
`define TPIO_HTRANS_ACTIVE_BIT 1

`endif

//--- common/tpio_pkg.sv
package tpio_pkg;

   typedef logic [7:0] tpio_byte_t;

   // One byte per port: index 0 is the first port, 2 the third.
   typedef logic [2:0][7:0] tpio_ports_t;

   typedef struct packed {
      logic write;
      logic in_map;
      logic [2:0] idx;
   } tpio_breq_s;

   typedef struct packed {
      logic level_mode;
      logic ext_mask;
   } tpio_ctrl_s;

   typedef enum logic {
      TPIO_BUS_IDLE,
      TPIO_BUS_DATA
   } tpio_bus_e;

endpackage : tpio_pkg

//--- rtl/tpio_top.sv
`timescale 1ns/1ps
`include "tpio_regs.svh"
module tpio_top #(
   parameter logic [7:0] PB_PULLUP_SEL = 8'hff
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hclken,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire tpio_pkg::tpio_ports_t pin_in,
   output tpio_pkg::tpio_ports_t pin_out,
   output tpio_pkg::tpio_ports_t pin_oe,
   output logic [7:0] pb_pullup_en,
   input wire logic ext_irq_n,
   input wire logic irq_ack,
   output logic ext_irq_req
);
   import tpio_pkg::*;

   // Index tables of the three ports, first port in slot 0.
   localparam logic [2:0] DATA_IDX [3] = '{`TPIO_IDX_A_DATA,
      `TPIO_IDX_B_DATA, `TPIO_IDX_C_DATA};
   localparam logic [2:0] DIR_IDX [3] = '{`TPIO_IDX_A_DIR,
      `TPIO_IDX_B_DIR, `TPIO_IDX_C_DIR};

   tpio_bus_e state;
   tpio_breq_s req;
   tpio_breq_s next_req;
   tpio_ctrl_s ctrl;
   tpio_ports_t latch;
   tpio_ports_t dir;
   tpio_ports_t pin_f;
   logic [24:0] sync1;
   logic [24:0] sync2;
   logic [24:0] sync3;
   logic [24:0] filt;
   logic edge_latch;
   logic line_low_d;

   // Address phase decode.
   wire addr_ok = hsel & htrans[`TPIO_HTRANS_ACTIVE_BIT] & hready;
   wire [2:0] addr_idx = haddr[`TPIO_IDX_MSB:`TPIO_IDX_LSB];
   wire addr_hi_zero = ~|haddr[`TPIO_ADDR_MSB:`TPIO_ADDR_HI_LSB];
   wire addr_in_map = addr_hi_zero & (addr_idx != `TPIO_IDX_HOLE);
   assign next_req = '{write: hwrite, in_map: addr_in_map, idx: addr_idx};

   // Data phase strobes.
   wire in_data = (state == TPIO_BUS_DATA);
   wire wr_go = in_data & req.write & req.in_map;
   wire ctrl_sel = req.in_map & (req.idx == `TPIO_IDX_IRQ_CTRL);
   wire [2:0] data_sel;
   wire [2:0] dir_sel;
   wire [2:0][7:0] rd_term;
   wire [7:0] ctrl_term = ctrl_sel ? {6'h00, ctrl} : 8'h00;
   wire [7:0] rd_byte = rd_term[0] | rd_term[1] | rd_term[2] | ctrl_term;
   wire [31:0] rd_word = {24'h000000, rd_byte};

   // Bus state machine: every transfer takes one wait state, so a write is
   // complete before any later read samples the registers.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= TPIO_BUS_IDLE;
         req <= '0;
         hreadyout <= 1'b1;
         hrdata <= 32'h00000000;
      end else if (hclken) begin
         case (state)
            TPIO_BUS_IDLE: begin
               if (addr_ok) begin
                  req <= next_req;
                  hreadyout <= 1'b0;
                  state <= TPIO_BUS_DATA;
               end
            end
            TPIO_BUS_DATA: begin
               hreadyout <= 1'b1;
               state <= TPIO_BUS_IDLE;
               if (!req.write) begin
                  hrdata <= rd_word;
               end
            end
            default: begin
               state <= TPIO_BUS_IDLE;
               hreadyout <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp <= `TPIO_HRESP_OKAY;
         pb_pullup_en <= PB_PULLUP_SEL;
      end else if (hclken) begin
         hresp <= `TPIO_HRESP_OKAY;
         pb_pullup_en <= PB_PULLUP_SEL;
      end
   end

   // Pin and external request synchronisers. A bit only counts once the
   // second and third stages agree, which also rejects a one-cycle glitch.
   wire [24:0] raw = {ext_irq_n, pin_in};
   wire [24:0] agree = ~(sync2 ^ sync3);
   wire [24:0] next_filt = (sync2 & agree) | (filt & ~agree);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1 <= `TPIO_SYNC_RESET;
         sync2 <= `TPIO_SYNC_RESET;
         sync3 <= `TPIO_SYNC_RESET;
         filt <= `TPIO_SYNC_RESET;
      end else if (hclken) begin
         sync1 <= raw;
         sync2 <= sync1;
         sync3 <= sync2;
         filt <= next_filt;
      end
   end

   assign pin_f = filt[23:0];
   wire irq_pin_high = filt[24];

   // Per-port data latch, direction register and read selection.
   genvar p;
   generate
      for (p = 0; p < 3; p++) begin : g_port
         assign data_sel[p] = req.in_map & (req.idx == DATA_IDX[p]);
         assign dir_sel[p] = req.in_map & (req.idx == DIR_IDX[p]);
         // Output bits read the latch, input bits the sensed level.
         wire [7:0] data_view = (dir[p] & latch[p]) | (~dir[p] & pin_f[p]);
         assign rd_term[p] = data_sel[p] ? data_view :
                             (dir_sel[p] ? dir[p] : 8'h00);

         // The latch has no reset: its content survives a reset, and the
         // pins stay undriven until software turns them into outputs.
         always_ff @(posedge hclk) begin
            if (hclken && wr_go && data_sel[p]) begin
               latch[p] <= hwdata[7:0];
            end
         end

         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               dir[p] <= `TPIO_DIR_RESET;
            end else if (hclken && wr_go && dir_sel[p]) begin
               dir[p] <= hwdata[7:0];
            end
         end
      end
   endgenerate

   assign pin_out = latch;
   assign pin_oe = dir;

   // Interrupt control register.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= `TPIO_CTRL_RESET;
      end else if (hclken && wr_go && ctrl_sel) begin
         ctrl.ext_mask <= hwdata[`TPIO_CTRL_MASK_BIT];
         ctrl.level_mode <= hwdata[`TPIO_CTRL_LEVEL_BIT];
      end
   end

   // Keyscan: only pulled-up second-port pins that are inputs take part.
   wire [7:0] key_en = PB_PULLUP_SEL & ~dir[1];
   wire [7:0] key_low = key_en & ~pin_f[1];
   wire line_low = ~irq_pin_high | (|key_low);
   wire line_fall = line_low & ~line_low_d;
   // A new edge in the acknowledge cycle is kept: set wins over clear.
   wire next_edge_latch = line_fall | (edge_latch & ~irq_ack);
   wire level_req = ctrl.level_mode & line_low;
   wire next_irq_req = ~ctrl.ext_mask & (edge_latch | level_req);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         line_low_d <= 1'b0;
         edge_latch <= 1'b0;
         ext_irq_req <= 1'b0;
      end else if (hclken) begin
         line_low_d <= line_low;
         edge_latch <= next_edge_latch;
         ext_irq_req <= next_irq_req;
      end
   end

   // Checks. Most are switched off while hclken is low, because a frozen
   // block legitimately holds every request and every wait state, and a
   // check that ran on frozen edges would compare against stale history.

   // Direction registers: a write lands on the enables one edge later.
   a_dir_write_oe: assert property (@(posedge hclk)
      disable iff (!hresetn || !hclken)
      (wr_go && dir_sel[1]) |=> (pin_oe[1] == $past(hwdata[7:0])))
      else $error("direction write not seen on output enables");

   a_dir_write_a: assert property (@(posedge hclk)
      disable iff (!hresetn || !hclken)
      (wr_go && dir_sel[0]) |=> (pin_oe[0] == $past(hwdata[7:0])))
      else $error("first port direction write not seen");

   a_dir_write_c: assert property (@(posedge hclk)
      disable iff (!hresetn || !hclken)
      (wr_go && dir_sel[2]) |=> (pin_oe[2] == $past(hwdata[7:0])))
      else $error("third port direction write not seen");

   // Without a direction write the first port's enables must not move at all.
   a_oe_hold: assert property (@(posedge hclk)
      disable iff (!hresetn || !hclken)
      !(wr_go && dir_sel[0]) |=> $stable(pin_oe[0]))
      else $error("first port enables changed without a write");

   a_reset_dir: assert property (@(posedge hclk)
      disable iff (!hresetn || !hclken)
      $rose(hresetn) |-> (pin_oe == '0))
      else $error("direction bits not cleared by reset");

   // Data latches: the write reaches the latch but never the direction.
   a_latch_write_pin: assert property (@(posedge hclk)
      disable iff (!hresetn || !hclken)
      (wr_go && data_sel[0]) |=> (pin_out[0] == $past(hwdata[7:0]))
      && $stable(pin_oe[0]))
      else $error("data write did not reach latch or changed direction");

   a_latch_write_b: assert property (@(posedge hclk)
      disable iff (!hresetn || !hclken)
      (wr_go && data_sel[1]) |=> (pin_out[1] == $past(hwdata[7:0]))
      && $stable(pin_oe[1]))
      else $error("second port data write went wrong");

   a_latch_write_c: assert property (@(posedge hclk)
      disable iff (!hresetn || !hclken)
      (wr_go && data_sel[2]) |=> (pin_out[2] == $past(hwdata[7:0]))
      && $stable(pin_oe[2]))
      else $error("third port data write went wrong");

   // Read path: each bit picks the latch or the sensed level by direction.
   a_read_mixed: assert property (@(posedge hclk)
      disable iff (!hresetn || !hclken)
      (in_data && !req.write && data_sel[2]) |=>
      (hrdata[7:0] == (($past(dir[2]) & $past(latch[2]))
      | (~$past(dir[2]) & $past(pin_f[2])))) && hreadyout)
      else $error("data read did not merge latch and pin by direction");

   a_read_a: assert property (@(posedge hclk)
      disable iff (!hresetn || !hclken)
      (in_data && !req.write && data_sel[0]) |=>
      (hrdata[7:0] == (($past(dir[0]) & $past(latch[0]))
      | (~$past(dir[0]) & $past(pin_f[0])))))
      else $error("first port data read went wrong");

   a_read_b: assert property (@(posedge hclk)
      disable iff (!hresetn || !hclken)
      (in_data && !req.write && data_sel[1]) |=>
      (hrdata[7:0] == (($past(dir[1]) & $past(latch[1]))
      | (~$past(dir[1]) & $past(pin_f[1])))))
      else $error("second port data read went wrong");

   a_dir_read: assert property (@(posedge hclk)
      disable iff (!hresetn || !hclken)
      (in_data && !req.write && dir_sel[0]) |=>
      (hrdata[7:0] == $past(dir[0])))
      else $error("direction read did not return the register");

   a_upper_zero: assert property (@(posedge hclk)
      disable iff (!hresetn)
      hrdata[31:8] == 24'h000000)
      else $error("read data above the port byte not zero");

   a_unmapped_zero: assert property (@(posedge hclk)
      disable iff (!hresetn || !hclken)
      (addr_ok && !hwrite && !addr_in_map && !in_data) |->
      ##2 (hrdata == 32'h00000000))
      else $error("unmapped read returned nonzero data");

   a_one_wait: assert property (@(posedge hclk)
      disable iff (!hresetn || !hclken)
      (addr_ok && !in_data) |=> !hreadyout ##1 hreadyout)
      else $error("transfer did not take exactly one wait state");

   a_okay_only: assert property (@(posedge hclk)
      disable iff (!hresetn)
      hresp == `TPIO_HRESP_OKAY)
      else $error("slave answered other than OKAY");

   // A filtered bit may only move on an edge where stages two and three
   // agreed, otherwise a single-cycle glitch would leak through.
   a_sync_agree: assert property (@(posedge hclk)
      disable iff (!hresetn || !hclken)
      ((filt ^ $past(filt)) & ($past(sync2) ^ $past(sync3))) == '0)
      else $error("filtered input moved without stage agreement");

   // Interrupt path.
   a_mask_blocks: assert property (@(posedge hclk)
      disable iff (!hresetn || !hclken)
      ext_irq_req |-> !$past(ctrl.ext_mask))
      else $error("request raised while the external mask was set");

   a_masked_quiet: assert property (@(posedge hclk)
      disable iff (!hresetn || !hclken)
      ctrl.ext_mask |=> !ext_irq_req)
      else $error("request follows a set external mask");

   a_output_no_key: assert property (@(posedge hclk)
      disable iff (!hresetn || !hclken)
      ((&dir[1]) && irq_pin_high) |-> !line_low)
      else $error("keyscan active on a second-port output pin");

   a_key_fall_latch: assert property (@(posedge hclk)
      disable iff (!hresetn || !hclken)
      (line_low && !line_low_d) |=> edge_latch)
      else $error("falling edge on the request line not latched");

   a_level_holds: assert property (@(posedge hclk)
      disable iff (!hresetn || !hclken)
      (ctrl.level_mode && !ctrl.ext_mask && line_low)[*2] |->
      ext_irq_req)
      else $error("level request not raised");

   a_key_reaches: assert property (@(posedge hclk)
      disable iff (!hresetn || !hclken)
      ((|key_low) && ctrl.level_mode && !ctrl.ext_mask)[*2] |->
      ext_irq_req)
      else $error("keyscan level did not reach the request");

   a_edge_sticks: assert property (@(posedge hclk)
      disable iff (!hresetn || !hclken)
      (edge_latch && !irq_ack && !ctrl.ext_mask) |=>
      (edge_latch && ext_irq_req))
      else $error("latched edge lost before acknowledge");

   a_ack_clears: assert property (@(posedge hclk)
      disable iff (!hresetn || !hclken)
      (irq_ack && !line_fall) |=> !edge_latch)
      else $error("acknowledge did not clear the latched edge");

   a_pullup_fixed: assert property (@(posedge hclk)
      disable iff (!hresetn)
      ##1 (pb_pullup_en == PB_PULLUP_SEL))
      else $error("pullup enables differ from build option");

   c_dir_write: cover property (@(posedge hclk) disable iff (!hresetn)
      wr_go && dir_sel[0]);
   c_read_input: cover property (@(posedge hclk) disable iff (!hresetn)
      in_data && !req.write && data_sel[1] && (dir[1] != 8'hff));
   c_key_irq: cover property (@(posedge hclk) disable iff (!hresetn)
      (|key_low) ##1 edge_latch ##1 ext_irq_req);
   c_unmapped: cover property (@(posedge hclk) disable iff (!hresetn)
      in_data && !req.in_map);
   c_level_irq: cover property (@(posedge hclk) disable iff (!hresetn)
      ctrl.level_mode && ext_irq_req);

endmodule : tpio_top

//--- tb/tpio_pin_model.sv
`timescale 1ns/1ps
module tpio_pin_model (
   input wire logic clk,
   input wire tpio_pkg::tpio_ports_t pin_out,
   input wire tpio_pkg::tpio_ports_t pin_oe,
   input wire logic [7:0] pb_pullup_en,
   input wire tpio_pkg::tpio_ports_t ext_val,
   input wire tpio_pkg::tpio_ports_t ext_en,
   output tpio_pkg::tpio_ports_t pin_in
);
   import tpio_pkg::*;
   tpio_ports_t last;
   // A released pin with no external drive and no pullup shows the inverse of its last level.
   always_comb begin
      for (int p = 0; p < 3; p++) begin
         for (int b = 0; b < 8; b++) begin
            if (pin_oe[p][b])
               pin_in[p][b] = pin_out[p][b];
            else if (ext_en[p][b])
               pin_in[p][b] = ext_val[p][b];
            else if (p == 1 && pb_pullup_en[b])
               pin_in[p][b] = 1'b1;
            else
               pin_in[p][b] = ~last[p][b];
         end
      end
   end
   always @(posedge clk) last <= pin_in;
endmodule : tpio_pin_model

//--- tb/testbench.sv
`timescale 1ns/1ps
`include "tpio_regs.svh"
module testbench;
   import tpio_pkg::*;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, irq_ack = 0;
   logic ext_irq_n = 1, hreadyout, hresp, ext_irq_req, hclken = 1;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [7:0] pb_pullup_en;
   tpio_ports_t pin_in, pin_out, pin_oe, ext_val = '1, ext_en = '1;
   int errors = 0, check_count = 0, lat[3], dir[3], ext[3], want;
   localparam logic [2:0] DAT[3] = '{`TPIO_IDX_A_DATA, `TPIO_IDX_B_DATA,
      `TPIO_IDX_C_DATA};
   localparam logic [2:0] DRX[3] = '{`TPIO_IDX_A_DIR, `TPIO_IDX_B_DIR,
      `TPIO_IDX_C_DIR};
   localparam logic [2:0] CTL = `TPIO_IDX_IRQ_CTRL;
   always #2 hclk = ~hclk;
   tpio_top dut (.hclk(hclk), .hresetn(hresetn), .hclken(hclken),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .pb_pullup_en(pb_pullup_en), .ext_irq_n(ext_irq_n),
      .irq_ack(irq_ack), .ext_irq_req(ext_irq_req));
   tpio_pin_model pins (.clk(hclk), .pin_out(pin_out), .pin_oe(pin_oe),
      .pb_pullup_en(pb_pullup_en), .ext_val(ext_val), .ext_en(ext_en),
      .pin_in(pin_in));
   task final_report;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : final_report
   task chk(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task xfer(input logic wr, input logic [2:0] idx, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {27'h0, idx, 2'h0};
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask : xfer
   task rd(input logic [2:0] idx, input int exp);
      xfer(1'b0, idx, 32'h0);
      chk("rdata", hrdata, exp);
   endtask : rd
   task ack;
      @(posedge hclk);
      irq_ack <= 1'b1;
      @(posedge hclk);
      irq_ack <= 1'b0;
   endtask : ack
   // Twelve cycles cover the three-flop filter plus the two request stages.
   task ireq(input logic exp);
      repeat (12) @(posedge hclk);
      chk("irq", ext_irq_req, exp);
   endtask : ireq
   initial begin
      void'($urandom(32'h988c));
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      chk("pullup", pb_pullup_en, 8'hff);
      for (int p = 0; p < 3; p++) rd(DRX[p], 0);
      xfer(1'b1, `TPIO_IDX_HOLE, 32'h55);
      rd(`TPIO_IDX_HOLE, 0);
      for (int r = 0; r < 4; r++) begin
         for (int p = 0; p < 3; p++) begin
            lat[p] = $urandom & 255;
            ext[p] = $urandom & 255;
            ext_val[p] <= ext[p][7:0];
            xfer(1'b1, DAT[p], lat[p]);
            chk("oe_keep", pin_oe[p], dir[p]);
            dir[p] = $urandom & 255;
            if (p == 2) dir[p] = dir[p] | 8'hf0;
            xfer(1'b1, DRX[p], dir[p]);
            chk("oe", pin_oe[p], dir[p]);
            chk("out", pin_out[p] & dir[p], lat[p] & dir[p]);
            repeat (6) @(posedge hclk);
            want = (dir[p] & lat[p]) | (~dir[p] & ext[p] & 255);
            rd(DAT[p], want);
            rd(DRX[p], dir[p]);
         end
      end
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int p = 0; p < 3; p++) begin
         chk("oe_rst", pin_oe[p], 0);
         chk("out_rst", pin_out[p], lat[p]);
      end
      ext_val[1] <= 8'hff;
      xfer(1'b1, CTL, 0);
      ack;
      ireq(1'b0);
      ext_val[1] <= 8'hf7;
      ireq(1'b1);
      ext_val[1] <= 8'hff;
      ack;
      ireq(1'b0);
      xfer(1'b1, CTL, 2);
      ext_val[1] <= 8'hf7;
      ack;
      ireq(1'b1);
      ext_val[1] <= 8'hff;
      ack;
      ireq(1'b0);
      xfer(1'b1, CTL, 0);
      xfer(1'b1, DAT[1], 8'h00);
      xfer(1'b1, DRX[1], 8'h08);
      ack;
      ireq(1'b0);
      xfer(1'b1, DAT[1], 8'hff);
      xfer(1'b1, DRX[1], 8'h00);
      xfer(1'b1, CTL, 1);
      ext_val[1] <= 8'hf7;
      ireq(1'b0);
      ext_irq_n <= 1'b0;
      ireq(1'b0);
      ext_val[1] <= 8'hff;
      ext_irq_n <= 1'b1;
      repeat (6) @(posedge hclk);
      ack;
      xfer(1'b1, CTL, 0);
      ireq(1'b0);
      // A frozen block must not pass the pin request on until it runs.
      hclken <= 1'b0;
      ext_irq_n <= 1'b0;
      ireq(1'b0);
      hclken <= 1'b1;
      ireq(1'b1);
      final_report;
   end
   // The whole sequence needs a few hundred cycles; this is far beyond it.
   initial begin
      #100000;
      errors++;
      final_report;
   end
endmodule : testbench
